/* File: src/pd_ctrl.sv */
// Host-side power-down sequencer driving CKE, CS and clock gating
`include "pd_ctrl_defines.svh"

module pd_ctrl
  import pd_ctrl_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst,
  // User side
  input  wire logic      pd_req,
  input  wire logic      sr_mode,
  input  wire cmd_kind_t cmd_kind,
  input  wire logic      cmd_valid,
  input  wire logic [CW-1:0] mrw_long_cyc,
  input  wire lat_cfg_t  lat_cfg,
  input  wire logic      refresh_due,
  output logic           pd_active,
  output logic           cmd_ready,
  output logic           clk_chg_ok,
  // Memory pins
  output logic           cke,
  output logic           cs,
  output logic           clk_run
);
  // --------------------------------------------------------------
  // Cycle counts
  // --------------------------------------------------------------
  // Each time limit is rounded up to whole clocks
  localparam logic [CW-1:0] CKELCS_C = CW'(`CYC_UP(`T_CKELCS_PS));
  // Entry clock hold is the larger of its time and clock-count minimums
  localparam logic [CW-1:0] CKELCK_T = CW'(`CYC_UP(`T_CKELCK_PS));
  localparam logic [CW-1:0] CKELCK_N = CW'(`T_CKELCK_NCK);
  localparam logic [CW-1:0] CKELCK_C = (CKELCK_T > CKELCK_N) ? CKELCK_T : CKELCK_N;
  localparam logic [CW-1:0] CKE_C    = CW'(`CYC_UP(`T_CKE_PS));
  localparam logic [CW-1:0] XP_C     = CW'(`CYC_UP(`T_XP_PS));
  localparam logic [CW-1:0] CMDCKE_C = CW'(`CYC_UP(`T_CMDCKE_PS));
  localparam logic [CW-1:0] MRWCKEL_C = CW'(`CYC_UP(`T_MRWCKEL_PS));
  localparam logic [CW-1:0] CKCKEH_C = CW'(`CYC_UP(`T_CKCKEH_PS));
  localparam logic [CW-1:0] DQSCK_C  = CW'(`CYC_UP(`T_DQSCK_MAX_PS));
  localparam logic [CW-1:0] WRX_C    = CW'(`CYC_UP(`T_DQSS_MAX_PS + `T_DQS2DQ_MAX_PS));
  localparam logic [CW-1:0] TWR_C    = CW'(`CYC_UP(`T_WR_PS));

  // --------------------------------------------------------------
  // Command hold-off counter
  // --------------------------------------------------------------
  logic [CW-1:0] hold_r;
  logic [CW-1:0] hold_nxt;
  logic          osc_r;
  logic          osc_nxt;
  logic [CW-1:0] need;
  logic [CW-1:0] half_bl;
  logic [CW-1:0] post_c;

  // Load the largest pending delay per command
  always_comb begin
    half_bl = CW'(lat_cfg.bl >> 1);
    post_c  = lat_cfg.post_long ? CW'(`POST_LONG_CYC) : CW'(`POST_SHORT_CYC);
    need    = '0;
    osc_nxt = osc_r;
    if (cmd_valid && cmd_ready) begin
      unique case (cmd_kind)
        CMD_RD, CMD_MRR: need = CW'(lat_cfg.rl) + DQSCK_C + half_bl + post_c;
        CMD_WR:  need = CW'(lat_cfg.wl) + WRX_C + half_bl + TWR_C;
        CMD_WRA: need = CW'(lat_cfg.wl) + WRX_C + half_bl + CW'(lat_cfg.nwr)
                        + CW'(`WRA_EXTRA_CYC) + CW'(1);
        CMD_ACT: need = CMDCKE_C;
        CMD_MRW: need = (mrw_long_cyc > MRWCKEL_C) ? mrw_long_cyc : MRWCKEL_C;
        CMD_OSC: osc_nxt = 1'b1;
        CMD_NONE: osc_nxt = 1'b0; // Oscillator run reported done
      endcase
    end
    hold_nxt = (hold_r != '0) ? hold_r - CW'(1) : '0;
    if (need > hold_nxt) begin
      hold_nxt = need;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_r <= '0;
      osc_r  <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      osc_r  <= osc_nxt;
    end
  end

  // --------------------------------------------------------------
  // Power-down sequencer
  // --------------------------------------------------------------
  pd_state_t     st_r;
  pd_state_t     st_nxt;
  logic [CW-1:0] tmr_r;
  logic [CW-1:0] tmr_nxt;
  logic [CW-1:0] lvl_r;
  logic [CW-1:0] lvl_nxt;
  logic          cke_r;
  logic          cke_nxt;
  logic          clk_r;
  logic          clk_nxt;
  logic          tmr_zero;
  logic          lvl_ok;

  assign tmr_zero = (tmr_r == '0);
  assign lvl_ok   = (lvl_r == '0);

  // Next state, timers and pin levels
  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_zero ? '0 : tmr_r - CW'(1);
    lvl_nxt = lvl_ok ? '0 : lvl_r - CW'(1);
    cke_nxt = cke_r;
    clk_nxt = clk_r;
    unique case (st_r)
      ST_AWAKE: begin
        if (pd_req && !refresh_due && hold_r == '0 && !osc_r && tmr_zero && lvl_ok
            && !cmd_valid) begin
          st_nxt  = ST_ENTER;
          cke_nxt = 1'b0;
          lvl_nxt = CKE_C - CW'(1);
          tmr_nxt = ((CKELCK_C > CKELCS_C) ? CKELCK_C : CKELCS_C) - CW'(1);
        end
      end
      ST_ENTER: begin
        if (tmr_zero) begin
          st_nxt = ST_DOWN;
        end
      end
      ST_DOWN: begin
        clk_nxt = sr_mode ? 1'b0 : 1'b1;
        if ((!pd_req || (refresh_due && !sr_mode)) && lvl_ok) begin
          st_nxt  = ST_CLKRDY;
          clk_nxt = 1'b1;
          tmr_nxt = CKCKEH_C;
        end
      end
      ST_CLKRDY: begin
        if (tmr_zero) begin
          st_nxt  = ST_EXIT;
          cke_nxt = 1'b1;
          lvl_nxt = CKE_C - CW'(1);
          tmr_nxt = XP_C - CW'(1);
        end
      end
      ST_EXIT: begin
        if (tmr_zero) begin
          st_nxt = ST_AWAKE;
        end
      end
      default: st_nxt = ST_AWAKE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r  <= ST_AWAKE;
      tmr_r <= '0;
      lvl_r <= '0;
      cke_r <= 1'b1;
      clk_r <= 1'b1;
    end else begin
      st_r  <= st_nxt;
      tmr_r <= tmr_nxt;
      lvl_r <= lvl_nxt;
      cke_r <= cke_nxt;
      clk_r <= clk_nxt;
    end
  end

  // Pins and user status
  assign cke        = cke_r;
  assign cs         = 1'b0;
  assign clk_run    = clk_r;
  assign pd_active  = (st_r != ST_AWAKE);
  assign cmd_ready  = (st_r == ST_AWAKE) && !(pd_req && hold_r == '0 && !osc_r);
  assign clk_chg_ok = (st_r == ST_DOWN) && hold_r == '0;

  // --------------------------------------------------------------
  // CKE level age
  // --------------------------------------------------------------
  logic [CW-1:0] age_r;
  logic [CW-1:0] age_nxt;

  // Cycles since CKE last moved; saturates so a long stay cannot wrap
  always_comb begin
    age_nxt = age_r;
    if (cke_nxt != cke_r) begin
      age_nxt = '0;
    end else if (age_r != '1) begin
      age_nxt = age_r + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age_r <= '1;
    end else begin
      age_r <= age_nxt;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  // A low CKE level lasts past the edge that follows its fall
  chk_cke_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cke) |=> !cke)
    else $error("CKE low not held");

  // A high CKE level lasts past the edge that follows its rise
  chk_rise_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cke) |=> cke)
    else $error("CKE high not held");

  // Every CKE level stands for the minimum level time
  chk_level_age: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(cke) |-> ($past(age_r) >= (CKE_C - CW'(1))))
    else $error("CKE level shorter than minimum");

  // CKE only falls once every command hold-off has run out
  chk_no_early_low: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cke) |-> $past(hold_r) == '0)
    else $error("CKE low before counters expired");

  // A command that needs CKE high loads the hold-off counter
  chk_hold_load: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_valid && cmd_ready && !(cmd_kind inside {CMD_OSC, CMD_NONE})) |=> (hold_r != '0))
    else $error("Hold-off not loaded");

  // No entry while an oscillator run is open
  chk_osc_block: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cke) |-> !$past(osc_r))
    else $error("Power-down during oscillator run");

  // An accepted oscillator start marks the run as open
  chk_osc_set: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_valid && cmd_ready && cmd_kind == CMD_OSC) |=> osc_r)
    else $error("Oscillator run not recorded");

  // No entry on the edge where a command is still offered
  chk_busy_block: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cke) |-> !$past(cmd_valid))
    else $error("Entry with a command pending");

  // The clock keeps running through the entry clock hold
  chk_clk_after: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cke) |-> clk_run [*5])
    else $error("Clock stopped early");

  // CS stays low while CKE is low
  chk_cs_low: assert property (@(posedge sys_clk) disable iff (rst)
    !cke |-> !cs)
    else $error("CS not low");

  // No command is taken while CKE is low
  chk_cmd_shut: assert property (@(posedge sys_clk) disable iff (rst)
    !cke |-> !cmd_ready)
    else $error("Command offered in power-down");

  // CKE stays low for the whole power-down state
  chk_pd_low: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_DOWN) |-> !cke)
    else $error("CKE high in power-down");

  // No command right after CKE rises
  chk_xp_wait: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cke) |-> !cmd_ready [*1])
    else $error("Command before tXP");

  // No command during the exit latency state
  chk_exit_wait: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_EXIT) |-> !cmd_ready)
    else $error("Command during exit latency");

  // The clock runs on the edge before CKE rises
  chk_clk_before_exit: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cke) |-> $past(clk_run))
    else $error("Clock not stable before exit");

  // The clock was already back two edges before CKE rises
  chk_clk_restart: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cke) |-> $past(clk_run, 2))
    else $error("Clock restarted too late");

  // No clock change inside the entry clock hold
  chk_chg_window: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cke) |-> !clk_chg_ok [*5])
    else $error("Clock change offered too early");

  // Clock change is only offered with CKE low
  chk_chg_in_pd: assert property (@(posedge sys_clk) disable iff (rst)
    clk_chg_ok |-> !cke)
    else $error("Clock change offered with CKE high");

  // The clock only stops in the power-down state
  chk_stop_in_pd: assert property (@(posedge sys_clk) disable iff (rst)
    !clk_run |-> (st_r == ST_DOWN))
    else $error("Clock stopped outside power-down");

  // A due refresh starts the exit from non-self-refresh power-down
  chk_refresh_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_DOWN && refresh_due && !sr_mode && lvl_ok) |=> (st_r == ST_CLKRDY))
    else $error("Refresh did not force exit");

  // No entry while a refresh is due
  chk_no_entry_due: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cke) |-> !$past(refresh_due))
    else $error("Entry with refresh due");
endmodule

/* File: src/pd_ctrl_defines.svh */
// Timing constants for the power-down controller
`ifndef PD_CTRL_DEFINES_SVH
`define PD_CTRL_DEFINES_SVH
`define CLK_PERIOD_PS      40000
`define T_CKELCS_PS        5000
`define T_CKELCK_PS        5000
`define T_CKELCK_NCK       5
`define T_CKE_PS           7500
`define T_XP_PS            7500
`define T_CMDCKE_PS        3750
`define T_MRWCKEL_PS       14000
`define T_ZQCKE_PS         3750
`define T_CKCKEH_PS        3750
`define T_DQSCK_MAX_PS     3600
`define T_DQSS_MAX_PS      1250
`define T_DQS2DQ_MAX_PS    800
`define T_WR_PS            18000
`define CYC_UP(ps)         (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define POST_SHORT_CYC     1
`define POST_LONG_CYC      2
`define WRA_EXTRA_CYC      2
`endif

/* File: src/pd_ctrl_pkg.sv */
// Types shared by the power-down controller
package pd_ctrl_pkg;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_RD   = 3'h1,
    CMD_MRR  = 3'h2,
    CMD_WR   = 3'h3,
    CMD_WRA  = 3'h4,
    CMD_ACT  = 3'h5,
    CMD_MRW  = 3'h6,
    CMD_OSC  = 3'h7
  } cmd_kind_t;

  typedef struct packed {
    logic [7:0] rl;
    logic [7:0] wl;
    logic [7:0] bl;
    logic [7:0] nwr;
    logic       post_long;
  } lat_cfg_t;

  typedef enum logic [2:0] {
    ST_AWAKE  = 3'h0,
    ST_ENTER  = 3'h1,
    ST_DOWN   = 3'h2,
    ST_CLKRDY = 3'h3,
    ST_EXIT   = 3'h4
  } pd_state_t;
endpackage

/* File: bench/lp_mem_model.sv */
// Memory model that tracks power-down from the pins
module lp_mem_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pins from the controller
  input  wire logic cke,
  input  wire logic cs,
  input  wire logic clk_run,
  // Model state
  output logic      in_pd,
  output logic      rx_on,
  output logic      viol
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clocks the controller must keep running once CKE is low
  localparam logic [7:0] HOLD_CYC = 8'h05;
  logic [7:0] low_r;

  // Power-down follows the CKE level and reset alone, whatever is in flight
  assign in_pd = !rst && cke === 1'b0;
  // Only CKE and reset are watched once the entry hold has run
  assign rx_on = !(in_pd && low_r >= HOLD_CYC);

  // Count clocks with CKE low; flag an early clock stop or a CS glitch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_r <= 8'h00;
      viol  <= 1'b0;
    end else if (!in_pd) begin
      low_r <= 8'h00;
    end else begin
      if (clk_run) low_r <= low_r + 8'h01;
      if ((!clk_run && low_r < HOLD_CYC) || cs !== 1'b0) viol <= 1'b1;
    end
  end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the power-down sequencer
module tb
  import pd_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        pd_req = 1'b0;
  logic        sr_mode = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        refresh_due = 1'b0;
  cmd_kind_t   cmd_kind = CMD_NONE;
  logic [15:0] mrw_long_cyc = 16'h0000;
  lat_cfg_t    lat_cfg = '{8'h04, 8'h03, 8'h08, 8'h05, 1'b0};
  logic        pd_active, cmd_ready, clk_chg_ok, cke, cs, clk_run, in_pd, rx_on, viol;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #20 sys_clk = ~sys_clk;

  pd_ctrl #(.CW(16)) dut_u (.sys_clk(sys_clk), .rst(rst), .pd_req(pd_req),
    .sr_mode(sr_mode), .cmd_kind(cmd_kind), .cmd_valid(cmd_valid),
    .mrw_long_cyc(mrw_long_cyc), .lat_cfg(lat_cfg), .refresh_due(refresh_due),
    .pd_active(pd_active), .cmd_ready(cmd_ready), .clk_chg_ok(clk_chg_ok),
    .cke(cke), .cs(cs), .clk_run(clk_run));
  lp_mem_model mem_u (.sys_clk(sys_clk), .rst(rst), .cke(cke), .cs(cs),
    .clk_run(clk_run), .in_pd(in_pd), .rx_on(rx_on), .viol(viol));

  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // Send one command, ask for power-down, time the entry, then leave
  task run(input cmd_kind_t k, input int d, input logic due);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_kind <= k;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    pd_req <= 1'b1;
    n = 0;
    while (cke !== 1'b0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n > d && n <= d + 4, "entry delay");
    chk(cs === 1'b0 && clk_run === 1'b1 && clk_chg_ok === 1'b0, "entry pins");
    repeat (6) @(negedge sys_clk);
    chk(pd_active === 1'b1 && in_pd === 1'b1 && rx_on === 1'b0, "not held");
    chk(clk_chg_ok === 1'b1, "clock change refused");
    @(posedge sys_clk);
    if (due) refresh_due <= 1'b1;
    else pd_req <= 1'b0;
    n = 0;
    while (cke !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= 2 && n <= 6 && clk_run === 1'b1, "exit timing");
    chk(cmd_ready === 1'b0 && clk_chg_ok === 1'b0, "exit latency");
    repeat (8) @(negedge sys_clk);
    chk(cke === 1'b1 && viol === 1'b0, "reentry or pin fault");
    @(posedge sys_clk);
    refresh_due <= 1'b0;
    pd_req <= 1'b0;
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence: every command kind, refresh exit, oscillator block
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(cke === 1'b1 && cs === 1'b0 && pd_active === 1'b0, "reset");
    run(CMD_RD, 10, 1'b0);
    lat_cfg.post_long <= 1'b1;
    run(CMD_RD, 11, 1'b0);
    run(CMD_MRR, 11, 1'b0);
    run(CMD_WR, 9, 1'b0);
    run(CMD_WRA, 16, 1'b0);
    run(CMD_ACT, 1, 1'b1);
    mrw_long_cyc <= 16'h0014;
    run(CMD_MRW, 20, 1'b0);
    sr_mode <= 1'b1;
    run(CMD_ACT, 1, 1'b0);
    @(posedge sys_clk);
    cmd_kind <= CMD_OSC;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    pd_req <= 1'b1;
    repeat (30) @(negedge sys_clk);
    chk(cke === 1'b1, "entry during oscillator run");
    @(posedge sys_clk);
    pd_req <= 1'b0;
    run(CMD_NONE, 0, 1'b0);
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule
